// ---- core/led_pwm_channel_core.sv ----
/*
  Output control core of a 36 channel LED current sink driver: register file,
  shadow update, shutdown gating and synchronised PWM generation.
  The global bits (soft shutdown, global disable, rate select) act at once;
  duty and channel control bytes wait in a shadow copy until the update
  command, so a host can rewrite many channels and switch them in one cycle.
  All channels compare one shared counter, so every lit output turns on at
  the same edge at the start of each period.
  Current scaling is only reported per channel on current_scale; the analog
  sinks that apply it sit outside this core.
  Assumes register writes arrive as single-cycle strobes on ref_clk from a
  serial slave, and that the shutdown pin is asynchronous to ref_clk.
  Assumes ref_clk runs at 40 MHz; the rate prescaler is fixed for that clock.
*/
//
// Function
// - A global disable bit of 1 forces every LED output off, 0 lets them run.
// - Bit 0 of the frequency register selects a common 3 kHz (0) or 22 kHz (1) PWM rate.
// - After reset the PWM rate is 3 kHz until software changes it.
// - Writing zero to the reset register at 4Fh returns every register to its default.
// - At power-up every register holds its default so all LEDs are dark.
// - Each of 36 channels takes brightness from its own 8-bit duty register at 01h to 24h.
// - Each channel takes its current level from the scale field of its own control register.
// - Register contents are kept unchanged during any shutdown mode.
// - A soft shutdown bit of 0 switches off all channel current sinks.
// - The device enters hardware shutdown whenever the shutdown pin is low.
// - All channel waveforms are synchronised and turn on together at each period start.
// - Duty and control writes stay in shadow storage until zero is written to 25h.
// - Control bit 0 turns a channel on, bits 2:1 select full, half, third or quarter current.
`timescale 1ns/10ps
`default_nettype none
module led_pwm_channel_core (
  input  wire logic                                   ref_clk,
  input  wire logic                                   sys_rst,
  input  wire led_pwm_pkg::reg_write_t                reg_wr,
  input  wire logic                                   shutdown_pin_n,
  output logic [led_pwm_pkg::CHANNELS-1:0]            led_sink_outputs,
  output logic [led_pwm_pkg::CHANNELS-1:0][1:0]       current_scale,
  output logic                                        soft_shutdown_n,
  output logic                                        pwm_freq_select,
  output logic                                        hw_shutdown
);
  import led_pwm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser.
  // The first flop may go metastable; only the second one is read below.
  logic sd_meta_reg;
  logic sd_sync_reg;
  logic sd_meta_next;
  logic sd_sync_next;

  always_comb begin
    sd_meta_next = shutdown_pin_n;
    sd_sync_next = sd_meta_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sd_meta_reg <= 1'b0;
      sd_sync_reg <= 1'b0;
    end else begin
      sd_meta_reg <= sd_meta_next;
      sd_sync_reg <= sd_sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode shared by the global bits and the channel slices.
  logic       wr_shutdown;
  logic       wr_global;
  logic       wr_freq;
  logic       wr_duty;
  logic       wr_ctrl;

  logic       cmd_reset;
  logic       cmd_update;

  logic [7:0] duty_idx;
  logic [7:0] ctrl_idx;

  always_comb begin
    // Offsets into the channel array; only valid while the range test holds.
    duty_idx    = reg_wr.addr - ADDR_DUTY_FIRST;
    ctrl_idx    = reg_wr.addr - ADDR_CTRL_FIRST;
    wr_shutdown = reg_wr.write && (reg_wr.addr == ADDR_SHUTDOWN);
    wr_global   = reg_wr.write && (reg_wr.addr == ADDR_GLOBAL);
    wr_freq     = reg_wr.write && (reg_wr.addr == ADDR_FREQ);
    wr_duty     = reg_wr.write && (reg_wr.addr >= ADDR_DUTY_FIRST) && (reg_wr.addr <= ADDR_DUTY_LAST);
    wr_ctrl     = reg_wr.write && (reg_wr.addr >= ADDR_CTRL_FIRST) && (reg_wr.addr <= ADDR_CTRL_LAST);
    // Unmapped addresses fall through every decode.
    // The update and reset commands act only on a data byte of zero.
    cmd_reset   = reg_wr.write && (reg_wr.addr == ADDR_RESET) && (reg_wr.data == CMD_TRIGGER);
    cmd_update  = reg_wr.write && (reg_wr.addr == ADDR_UPDATE) && (reg_wr.data == CMD_TRIGGER);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global control bits. Writes land in every shutdown mode and only the
  // reset command or sys_rst clears them.
  // A global disable of 1 darkens every channel but leaves all settings alone.
  logic soft_on_reg;
  logic soft_on_next;
  logic gdis_reg;
  logic gdis_next;
  logic freq_reg;
  logic freq_next;

  always_comb begin
    soft_on_next = soft_on_reg;
    gdis_next    = gdis_reg;
    freq_next    = freq_reg;
    if (wr_shutdown) begin
      soft_on_next = reg_wr.data[BIT_ENABLE];
    end
    if (wr_global) begin
      gdis_next = reg_wr.data[BIT_ENABLE];
    end
    if (wr_freq) begin
      freq_next = reg_wr.data[BIT_ENABLE];
    end
    // The reset command outranks any other effect in the same cycle.
    if (cmd_reset) begin
      soft_on_next = RESET_BYTE[0];
      gdis_next    = RESET_BYTE[0];
      freq_next    = RESET_BYTE[0];
    end
  end

  // sys_rst gives the power-up defaults: nothing lit and the low rate.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      soft_on_reg <= RESET_BYTE[0];
      gdis_reg    <= RESET_BYTE[0];
      freq_reg    <= RESET_BYTE[0];
    end else begin
      soft_on_reg <= soft_on_next;
      gdis_reg    <= gdis_next;
      freq_reg    <= freq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow and applied settings, one slice per channel. Only the applied copy
  // reaches the comparators, so host writes never show up mid-update.
  // Slices run from channel 1 at index 0 up to channel 36 at index 35.
  channel_cfg_t shadow_reg  [CHANNELS];
  channel_cfg_t applied_reg [CHANNELS];

  genvar rc;
  generate
    for (rc = 0; rc < CHANNELS; rc++) begin : g_regs
      channel_cfg_t shadow_next;
      channel_cfg_t applied_next;

      // Comparing the offset with the slice number keeps each write to one slice.
      always_comb begin
        shadow_next  = shadow_reg[rc];
        applied_next = applied_reg[rc];
        if (wr_duty && (duty_idx == 8'(rc))) begin
          shadow_next.duty = reg_wr.data;
        end
        if (wr_ctrl && (ctrl_idx == 8'(rc))) begin
          shadow_next.on            = reg_wr.data[BIT_ON];
          shadow_next.current_scale = reg_wr.data[SCALE_MSB:SCALE_LSB];
        end
        // The update copies the shadow as it stood before a same-cycle write.
        if (cmd_update) begin
          applied_next = shadow_reg[rc];
        end
        // A reset command clears both copies, so no stale setting applies later.
        if (cmd_reset) begin
          shadow_next  = '0;
          applied_next = '0;
        end
      end

      // Each slice owns its own elements, so no two processes drive one variable.
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          shadow_reg[rc]  <= '0;
          applied_reg[rc] <= '0;
        end else begin
          shadow_reg[rc]  <= shadow_next;
          applied_reg[rc] <= applied_next;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler that sets the PWM rate. A rate change takes effect at the next
  // compare without restarting the counter; the >= catches a prescaler that
  // sits above the new, shorter top.
  // At 40 MHz the low rate divides by 52 and the high rate by 7, giving about
  // 3.0 kHz and 22.3 kHz; the integer division rounds toward the faster side.
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] presc_next;
  logic [PRESC_W-1:0] presc_top;

  logic               presc_wrap;

  always_comb begin
    presc_top  = freq_reg ? PRESC_HIGH_CYC : PRESC_LOW_CYC;
    presc_wrap = (presc_reg >= presc_top - 8'h01);
    presc_next = presc_reg + 8'h01;
    if (presc_wrap) begin
      presc_next = PRESC_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      presc_reg <= PRESC_RESET;
    end else begin
      presc_reg <= presc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free-running PWM counter shared by every channel.
  // The wrap from 255 to 0 starts every PWM period.
  // A duty of 0 never lights and 255 lights for all but one count.
  logic [7:0] count_reg;
  logic [7:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (presc_wrap) begin
      count_next = count_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output gate and registered status copies.
  logic run_gate;

  logic hw_sd_reg;
  logic hw_sd_next;
  logic soft_out_reg;
  logic soft_out_next;
  logic freq_out_reg;
  logic freq_out_next;

  always_comb begin
    // Gate off on soft shutdown, pin low or global disable.
    run_gate      = soft_on_reg && sd_sync_reg && !gdis_reg;
    hw_sd_next    = !sd_sync_reg;
    soft_out_next = soft_on_reg;
    freq_out_next = freq_reg;
  end

  // hw_shutdown starts high because the synchroniser resets to pin low.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hw_sd_reg    <= 1'b1;
      soft_out_reg <= 1'b0;
      freq_out_reg <= 1'b0;
    end else begin
      hw_sd_reg    <= hw_sd_next;
      soft_out_reg <= soft_out_next;
      freq_out_reg <= freq_out_next;
    end
  end

  // Status outputs lag their registers by one cycle, like the sink outputs.
  // current_scale keeps driving in shutdown; only the sink outputs are gated.
  assign hw_shutdown     = hw_sd_reg;
  assign soft_shutdown_n = soft_out_reg;
  assign pwm_freq_select = freq_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel comparators, all fed by one counter. Each registers its own
  // output, so the 36 sink outputs change on one common edge, one cycle after
  // the counter, and the scales one cycle after the applied copy.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      led_pwm_compare u_cmp (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .pwm_count (count_reg),
        .run_gate  (run_gate),
        .cfg       (applied_reg[ch]),
        .sink_on   (led_sink_outputs[ch]),
        .scale     (current_scale[ch])
      );
    end
  endgenerate

endmodule // led_pwm_channel_core
`default_nettype wire

// ---- core/led_pwm_compare.sv ----
/*
  One PWM comparator per channel with registered output.
  Assumes the shared counter and a gate that is high when outputs may run.
*/
`timescale 1ns/10ps
`default_nettype none
module led_pwm_compare (
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic [7:0]              pwm_count,
  input  wire logic                    run_gate,
  input  wire led_pwm_pkg::channel_cfg_t cfg,
  output logic                         sink_on,
  output logic [1:0]                   scale
);
  import led_pwm_pkg::*;

  logic       sink_on_next;
  logic [1:0] scale_next;

  always_comb begin
    sink_on_next = run_gate && cfg.on && (pwm_count < cfg.duty);
    scale_next   = cfg.current_scale;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sink_on <= 1'b0;
      scale   <= 2'b00;
    end else begin
      sink_on <= sink_on_next;
      scale   <= scale_next;
    end
  end
endmodule // led_pwm_compare
`default_nettype wire

// ---- core/led_pwm_pkg.sv ----
/*
  Shared constants and carrier types for the LED PWM channel core.
  Assumes a 40 MHz reference clock and a byte-wide register write port
  driven by a serial slave decoder outside this core.
*/
package led_pwm_pkg;

  localparam int unsigned CHANNELS     = 36;
  localparam int unsigned REF_CLK_HZ   = 40_000_000;
  localparam int unsigned PWM_STEPS    = 256;
  localparam int unsigned FREQ_LOW_HZ  = 3_000;
  localparam int unsigned FREQ_HIGH_HZ = 22_000;
  localparam int unsigned PRESC_LOW    = REF_CLK_HZ / (FREQ_LOW_HZ * PWM_STEPS);
  localparam int unsigned PRESC_HIGH   = REF_CLK_HZ / (FREQ_HIGH_HZ * PWM_STEPS);
  localparam int unsigned PRESC_W      = 8;
  localparam logic [PRESC_W-1:0] PRESC_LOW_CYC  = PRESC_W'(PRESC_LOW);
  localparam logic [PRESC_W-1:0] PRESC_HIGH_CYC = PRESC_W'(PRESC_HIGH);

  localparam logic [7:0] ADDR_SHUTDOWN   = 8'h00;
  localparam logic [7:0] ADDR_DUTY_FIRST = 8'h01;
  localparam logic [7:0] ADDR_DUTY_LAST  = 8'h24;
  localparam logic [7:0] ADDR_UPDATE     = 8'h25;
  localparam logic [7:0] ADDR_CTRL_FIRST = 8'h26;
  localparam logic [7:0] ADDR_CTRL_LAST  = 8'h49;
  localparam logic [7:0] ADDR_GLOBAL     = 8'h4A;
  localparam logic [7:0] ADDR_FREQ       = 8'h4B;
  localparam logic [7:0] ADDR_RESET      = 8'h4F;
  localparam logic [7:0] CMD_TRIGGER     = 8'h00;

  localparam int unsigned BIT_ENABLE     = 0;
  localparam int unsigned BIT_ON         = 0;
  localparam int unsigned SCALE_LSB      = 1;
  localparam int unsigned SCALE_MSB      = 2;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 8'h00;

  typedef enum logic [1:0] {
    SCALE_FULL,
    SCALE_HALF,
    SCALE_THIRD,
    SCALE_QUARTER
  } current_scale_t;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    logic [7:0] duty;
    logic [1:0] current_scale;
    logic       on;
  } channel_cfg_t;

endpackage

// ---- tb/led_pwm_channel_core_bench.sv ----
/*
  Self-checking bench for the LED PWM channel core.
  Assumes the host model drives all core inputs except clock and reset.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module led_pwm_channel_core_bench;
  import led_pwm_pkg::*;
  logic                     ref_clk, sys_rst, shutdown_pin_n, soft_shutdown_n, pwm_freq_select, hw_shutdown;
  reg_write_t               reg_wr;
  logic [CHANNELS-1:0]      led_sink_outputs;
  logic [CHANNELS-1:0][1:0] current_scale;
  int                       fails = 0, num_checks = 0, c0, c35, skew;
  localparam int            P_LO = 256 * PRESC_LOW;
  localparam int            P_HI = 256 * PRESC_HIGH;
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  led_pwm_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .shutdown_pin_n(shutdown_pin_n));
  led_pwm_channel_core uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .shutdown_pin_n(shutdown_pin_n),
    .led_sink_outputs(led_sink_outputs), .current_scale(current_scale), .soft_shutdown_n(soft_shutdown_n),
    .pwm_freq_select(pwm_freq_select), .hw_shutdown(hw_shutdown));
  ////////////////////////////////////////////////////////////////////////////
  // Counts active cycles of channels 1 and 36 and any cycle where 1 and 2 differ.
  task automatic meas(input int n);
    c0 = 0;
    c35 = 0;
    skew = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      c0 += (led_sink_outputs[0] === 1'b1);
      c35 += (led_sink_outputs[35] === 1'b1);
      skew += (led_sink_outputs[0] !== led_sink_outputs[1]);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #(25 * 40000);
    fails++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    `CHK("leds", '0, led_sink_outputs)
    `CHK("freq", 1'b0, pwm_freq_select)
    `CHK("soft", 1'b0, soft_shutdown_n)
    host.set_pin(1'b1);
    host.wr(ADDR_SHUTDOWN, 8'h01);
    host.wr(8'h01, 8'h04);
    host.wr(8'h02, 8'h04);
    host.wr(ADDR_DUTY_LAST, 8'hFF);
    host.wr(ADDR_CTRL_FIRST, 8'h03);
    host.wr(8'h27, 8'h01);
    host.wr(ADDR_CTRL_LAST, 8'h07);
    host.wr(ADDR_UPDATE, 8'h01);
    meas(600);
    `CHK("shadow", 0, c35)
    `CHK("scale0", 2'h0, current_scale[0])
    host.wr(ADDR_UPDATE, CMD_TRIGGER);
    host.wr(8'h4C, 8'hFF);
    meas(P_LO);
    `CHK("ch1 lo", 4 * PRESC_LOW, c0)
    `CHK("ch36 lo", 255 * PRESC_LOW, c35)
    `CHK("skew", 0, skew)
    `CHK("scale0", 2'h1, current_scale[0])
    `CHK("scale35", 2'h3, current_scale[35])
    `CHK("freq", 1'b0, pwm_freq_select)
    $display("test duty done");
    host.wr(ADDR_FREQ, 8'h01);
    meas(1);
    `CHK("freq", 1'b1, pwm_freq_select)
    meas(300);
    meas(P_HI);
    `CHK("ch1 hi", 4 * PRESC_HIGH, c0)
    host.wr(ADDR_GLOBAL, 8'h01);
    meas(P_HI);
    `CHK("global", 0, c0 + c35)
    host.wr(ADDR_GLOBAL, 8'h00);
    meas(P_HI);
    `CHK("kept", 255 * PRESC_HIGH, c35)
    host.wr(ADDR_SHUTDOWN, 8'h00);
    meas(P_HI);
    `CHK("soft", 0, c35)
    `CHK("scale0", 2'h1, current_scale[0])
    host.wr(ADDR_SHUTDOWN, 8'h01);
    host.set_pin(1'b0);
    meas(P_HI);
    `CHK("pin", 0, c35)
    `CHK("hw", 1'b1, hw_shutdown)
    host.set_pin(1'b1);
    meas(P_HI);
    `CHK("kept", 255 * PRESC_HIGH, c35)
    $display("test shutdown done");
    host.wr(ADDR_CTRL_FIRST, 8'h02);
    host.wr(8'h27, 8'h05);
    host.wr(ADDR_UPDATE, CMD_TRIGGER);
    meas(P_HI);
    `CHK("off", 0, c0)
    `CHK("scale1", 2'h2, current_scale[1])
    `CHK("ch36", 255 * PRESC_HIGH, c35)
    host.wr(ADDR_RESET, 8'h05);
    `CHK("freq", 1'b1, pwm_freq_select)
    host.wr(ADDR_RESET, CMD_TRIGGER);
    meas(2);
    `CHK("freq", 1'b0, pwm_freq_select)
    `CHK("soft", 1'b0, soft_shutdown_n)
    `CHK("scale35", 2'h0, current_scale[35])
    `CHK("leds", '0, led_sink_outputs)
    $display("test reset command done");
    conclude();
  end
endmodule // led_pwm_channel_core_bench
`default_nettype wire

// ---- tb/led_pwm_channel_core_checker.sv ----
/*
  Concurrent checks on the ports of the LED PWM channel core.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module led_pwm_channel_core_checker (
  input wire logic                              ref_clk,
  input wire logic                              sys_rst,
  input wire led_pwm_pkg::reg_write_t           reg_wr,
  input wire logic                              shutdown_pin_n,
  input wire logic [led_pwm_pkg::CHANNELS-1:0]  led_sink_outputs,
  input wire logic [led_pwm_pkg::CHANNELS-1:0][1:0] current_scale,
  input wire logic                              soft_shutdown_n,
  input wire logic                              pwm_freq_select,
  input wire logic                              hw_shutdown
);
  import led_pwm_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] quiet_reg;
  logic [1:0] quiet_next;
  // Counts quiet cycles since the last register write, saturating at three.
  always_comb quiet_next = reg_wr.write ? 2'h0 : ((quiet_reg == 2'h3) ? quiet_reg : quiet_reg + 2'h1);
  always_ff @(posedge ref_clk) quiet_reg <= sys_rst ? 2'h0 : quiet_next;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_pin_low;
    !shutdown_pin_n [*3];
  endsequence
  sequence s_pin_high;
    shutdown_pin_n [*3];
  endsequence
  sequence s_reset_cmd;
    reg_wr.write && reg_wr.addr == ADDR_RESET && reg_wr.data == CMD_TRIGGER ##1 !reg_wr.write;
  endsequence
  AST_RST: assert property (disable iff (1'b0) sys_rst |=> led_sink_outputs == '0 && !soft_shutdown_n)
    else $error("outputs not dark after reset");
  AST_SOFT_GATE: assert property (!soft_shutdown_n |-> led_sink_outputs == '0)
    else $error("output active in soft shutdown");
  AST_HW_GATE: assert property (hw_shutdown |-> led_sink_outputs == '0)
    else $error("output active in hardware shutdown");
  AST_PIN_LOW: assert property (s_pin_low |=> hw_shutdown)
    else $error("pin low not seen as shutdown");
  AST_PIN_HIGH: assert property (s_pin_high |=> !hw_shutdown)
    else $error("pin high still seen as shutdown");
  AST_FREQ_WR: assert property (reg_wr.write && reg_wr.addr == ADDR_FREQ |-> ##2 pwm_freq_select == $past(reg_wr.data[0], 2))
    else $error("frequency select does not follow write");
  AST_SOFT_WR: assert property (reg_wr.write && reg_wr.addr == ADDR_SHUTDOWN |-> ##2 soft_shutdown_n == $past(reg_wr.data[0], 2))
    else $error("soft shutdown does not follow write");
  AST_RESET_CMD: assert property (s_reset_cmd |=> led_sink_outputs == '0 && current_scale == '0 && !soft_shutdown_n && !pwm_freq_select)
    else $error("reset command left state behind");
  AST_SYNC: assert property (quiet_reg == 2'h3 && !hw_shutdown && !$past(hw_shutdown) && |(led_sink_outputs & ~$past(led_sink_outputs)) |-> $past(led_sink_outputs) == '0)
    else $error("channel turned on out of step");
endmodule // led_pwm_channel_core_checker
bind led_pwm_channel_core led_pwm_channel_core_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
  .shutdown_pin_n(shutdown_pin_n), .led_sink_outputs(led_sink_outputs), .current_scale(current_scale),
  .soft_shutdown_n(soft_shutdown_n), .pwm_freq_select(pwm_freq_select), .hw_shutdown(hw_shutdown));
`default_nettype wire

// ---- tb/led_pwm_host_model.sv ----
/*
  Host model that writes the core's registers and drives the shutdown pin.
  Assumes the core samples one write strobe per rising edge of ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module led_pwm_host_model (
  input  wire logic                   ref_clk,
  output var  led_pwm_pkg::reg_write_t reg_wr,
  output logic                        shutdown_pin_n
);
  import led_pwm_pkg::*;
  initial begin
    reg_wr = '{1'b0, 8'hFF, 8'hFF};
    shutdown_pin_n = 1'b0;
  end
  // Idle bus shows the inverse of the last byte so stale data is never reused.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_wr = '{1'b1, a, d};
    @(posedge ref_clk);
    #1 reg_wr = '{1'b0, ~a, ~d};
  endtask
  // Waits out the pin synchroniser before returning.
  task automatic set_pin(input logic v);
    @(posedge ref_clk);
    #1 shutdown_pin_n = v;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
endmodule // led_pwm_host_model
`default_nettype wire
